// >>> verilog/clmu_params.svh
// Constants for the combine-OR and word-select logic unit
//
// Notes on behaviour
// - Apply logic function, then OR each word
// - Word size comes from two-bit size field
// - SIMD flag reduces every sub-word separately
// - Function field selects one of eight functions
// - All-ones control word picks third operand
// - Word-select writes to paired register index
// - One cycle latency, one operation per cycle
`ifndef CLMU_PARAMS_SVH
`define CLMU_PARAMS_SVH

// ----------------------------------------------------------------
// Instruction word fields
// ----------------------------------------------------------------
`define CLMU_OPC_MSB    31
`define CLMU_OPC_LSB    24
`define CLMU_SIZE_MSB   23
`define CLMU_SIZE_LSB   22
`define CLMU_SIMD_BIT   21
`define CLMU_FUNC_MSB   20
`define CLMU_FUNC_LSB   18
`define CLMU_REG1_MSB   5
`define CLMU_REG1_LSB   0

// ----------------------------------------------------------------
// Size field codes
// ----------------------------------------------------------------
`define CLMU_SZ_BYTE    2'h0
`define CLMU_SZ_DOUBLE  2'h1
`define CLMU_SZ_QUAD    2'h2
`define CLMU_SZ_FULL    2'h3

// ----------------------------------------------------------------
// Function field codes
// ----------------------------------------------------------------
`define CLMU_FN_AND     3'h0
`define CLMU_FN_ANDN    3'h1
`define CLMU_FN_XOR     3'h2
`define CLMU_FN_OR      3'h3
`define CLMU_FN_NOR     3'h4
`define CLMU_FN_XNOR    3'h5
`define CLMU_FN_ORN     3'h6
`define CLMU_FN_NAND    3'h7

// ----------------------------------------------------------------
// Misc
// ----------------------------------------------------------------
`define CLMU_PAIR_MASK  6'h01
`define CLMU_OPC_COR    8'h40
`define CLMU_OPC_MUX    8'h41
`define CLMU_BYTE_W     8
`define CLMU_NUM_SIZES  4

`endif

// >>> verilog/clmu_pkg.sv
// Types shared by the combine-OR and word-select logic unit
`include "clmu_params.svh"

package clmu_pkg;

  typedef logic [7:0] clmu_opc_t;
  typedef logic [5:0] clmu_reg_idx_t;
  typedef logic [31:0] clmu_instr_t;

  // Word size selections
  typedef enum logic [1:0] {
    CLMU_SIZE_BYTE   = `CLMU_SZ_BYTE,
    CLMU_SIZE_DOUBLE = `CLMU_SZ_DOUBLE,
    CLMU_SIZE_QUAD   = `CLMU_SZ_QUAD,
    CLMU_SIZE_FULL   = `CLMU_SZ_FULL
  } clmu_size_e;

endpackage : clmu_pkg

// >>> verilog/clmu_top.sv
// Combine-OR and word-select datapath of the three-operand logic unit
`timescale 1ns/1ps
`include "clmu_params.svh"

module clmu_top #(
  parameter int                 DATA_W             = 64,
  parameter clmu_pkg::clmu_opc_t COMBINE_OR_OPCODE  = `CLMU_OPC_COR,
  parameter clmu_pkg::clmu_opc_t WORD_SELECT_OPCODE = `CLMU_OPC_MUX
) (
  input  wire logic                  clk_sys,
  input  wire logic                  reset_n,
  input  wire logic                  op_valid,
  input  wire clmu_pkg::clmu_instr_t instr,
  input  wire logic [DATA_W-1:0]     src1_data,
  input  wire logic [DATA_W-1:0]     src2_data,
  input  wire logic [DATA_W-1:0]     src3_data,
  output logic                       res_valid_ff,
  output clmu_pkg::clmu_reg_idx_t    res_index_ff,
  output logic [DATA_W-1:0]          res_data_ff
);
  import clmu_pkg::*;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Bitwise function of second and third operand
  function automatic logic [DATA_W-1:0] clmu_logic(
    input logic [2:0]        fn,
    input logic [DATA_W-1:0] x,
    input logic [DATA_W-1:0] y
  );
    logic [DATA_W-1:0] r;
    r = '0;
    case (fn)
      `CLMU_FN_AND:  r = x & y;
      `CLMU_FN_ANDN: r = x & ~y;
      `CLMU_FN_XOR:  r = x ^ y;
      `CLMU_FN_OR:   r = x | y;
      `CLMU_FN_NOR:  r = ~(x | y);
      `CLMU_FN_XNOR: r = ~(x ^ y);
      `CLMU_FN_ORN:  r = x | ~y;
      `CLMU_FN_NAND: r = ~(x & y);
      default:       r = '0;
    endcase
    return r;
  endfunction : clmu_logic

  // Mask of the lowest word for a size code
  function automatic logic [DATA_W-1:0] clmu_low_mask(input clmu_size_e sz);
    logic [DATA_W-1:0] m;
    m = '0;
    case (sz)
      CLMU_SIZE_BYTE:   m = {{(DATA_W-8){1'b0}}, 8'hff};
      CLMU_SIZE_DOUBLE: m = {{(DATA_W-16){1'b0}}, 16'hffff};
      CLMU_SIZE_QUAD:   m = {{(DATA_W-32){1'b0}}, 32'hffff_ffff};
      CLMU_SIZE_FULL:   m = '1;
      default:          m = '0;
    endcase
    return m;
  endfunction : clmu_low_mask

  // Size field of an instruction word
  function automatic clmu_size_e clmu_size_of(input clmu_instr_t iw);
    return clmu_size_e'(iw[`CLMU_SIZE_MSB:`CLMU_SIZE_LSB]);
  endfunction : clmu_size_of

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------

  wire clmu_opc_t     opc_fld   = instr[`CLMU_OPC_MSB:`CLMU_OPC_LSB];
  wire clmu_size_e    size_sel  = clmu_size_of(instr);
  wire logic          simd_en   = instr[`CLMU_SIMD_BIT];
  wire logic [2:0]    func_sel  = instr[`CLMU_FUNC_MSB:`CLMU_FUNC_LSB];
  wire clmu_reg_idx_t reg1_idx  = instr[`CLMU_REG1_MSB:`CLMU_REG1_LSB];
  wire logic          is_cor    = (opc_fld == COMBINE_OR_OPCODE);
  wire logic          is_mux    = (opc_fld == WORD_SELECT_OPCODE);
  wire logic          accept    = op_valid & (is_cor | is_mux);

  // ----------------------------------------------------------------
  // Per-word reductions for every size
  // ----------------------------------------------------------------

  // Bitwise function first, reductions after it
  wire logic [DATA_W-1:0] func_val = clmu_logic(func_sel, src2_data, src3_data);

  logic [DATA_W-1:0] or_exp  [`CLMU_NUM_SIZES];
  logic [DATA_W-1:0] all_exp [`CLMU_NUM_SIZES];

  // Each word spread back to its full width
  for (genvar s = 0; s < `CLMU_NUM_SIZES; s++) begin : g_size
    localparam int SZ = `CLMU_BYTE_W << s;
    for (genvar w = 0; w < DATA_W / SZ; w++) begin : g_word
      assign or_exp[s][w*SZ +: SZ]  = {SZ{|func_val[w*SZ +: SZ]}};
      assign all_exp[s][w*SZ +: SZ] = {SZ{&src2_data[w*SZ +: SZ]}};
    end
  end

  // ----------------------------------------------------------------
  // Result selection
  // ----------------------------------------------------------------

  // Scalar form keeps only the lowest word
  wire logic [DATA_W-1:0] cor_keep  = simd_en ? '1 : clmu_low_mask(size_sel);
  wire logic [DATA_W-1:0] cor_res   = or_exp[size_sel] & cor_keep;
  wire logic [DATA_W-1:0] sel_mask  = all_exp[size_sel];
  wire logic [DATA_W-1:0] mux_res   = (sel_mask & src3_data) |
                                      (~sel_mask & src1_data);

  // Destination: paired register for word-select
  wire clmu_reg_idx_t     nxt_index = is_mux ? (reg1_idx ^ `CLMU_PAIR_MASK)
                                             : reg1_idx;
  wire logic [DATA_W-1:0] nxt_data  = is_mux ? mux_res : cor_res;

  // ----------------------------------------------------------------
  // Result register
  // ----------------------------------------------------------------

  // One stage, new operation every cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      res_valid_ff <= 1'b0;
      res_index_ff <= '0;
      res_data_ff  <= '0;
    end else begin
      res_valid_ff <= accept;
      if (accept) begin
        res_index_ff <= nxt_index;
        res_data_ff  <= nxt_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // Issue of each operation kind
  sequence s_cor_issue;
    op_valid && is_cor;
  endsequence

  sequence s_mux_issue;
    op_valid && is_mux;
  endsequence

  sequence s_cor_byte_simd;
    s_cor_issue ##0 (size_sel == CLMU_SIZE_BYTE) && simd_en;
  endsequence

  a_latency_one:
    assert property (accept |=> res_valid_ff ##1 (res_valid_ff == $past(accept)))
    else $error("result not valid one cycle after issue");

  a_no_spurious:
    assert property (!accept |=> !res_valid_ff)
    else $error("result valid without an issue");

  a_pair_index:
    assert property (s_mux_issue |=> res_index_ff == ($past(reg1_idx) ^ `CLMU_PAIR_MASK))
    else $error("word-select destination is not the paired register");

  a_cor_index:
    assert property (s_cor_issue |=> res_index_ff == $past(reg1_idx))
    else $error("combine-OR destination wrong");

  a_full_and:
    assert property (s_cor_issue ##0 (func_sel == `CLMU_FN_AND) && (size_sel == CLMU_SIZE_FULL)
                     |=> res_data_ff == {DATA_W{|($past(src2_data) & $past(src3_data))}})
    else $error("full-width and reduction wrong");

  a_full_orn:
    assert property (s_cor_issue ##0 (func_sel == `CLMU_FN_ORN) && (size_sel == CLMU_SIZE_FULL)
                     |=> res_data_ff == {DATA_W{|($past(src2_data) | ~$past(src3_data))}})
    else $error("full-width orn reduction wrong");

  a_byte_lane:
    assert property (s_cor_byte_simd ##0 (func_sel == `CLMU_FN_XOR)
                     |=> res_data_ff[15:8] ==
                         {8{|($past(src2_data[15:8]) ^ $past(src3_data[15:8]))}})
    else $error("byte lane one of xor reduction wrong");

  a_scalar_upper:
    assert property (s_cor_issue ##0 !simd_en && (size_sel == CLMU_SIZE_QUAD)
                     |=> res_data_ff[DATA_W-1:32] == '0)
    else $error("scalar combine-OR left upper words set");

  a_simd_quad:
    assert property (s_cor_issue ##0 simd_en && (size_sel == CLMU_SIZE_QUAD) &&
                     (func_sel == `CLMU_FN_OR)
                     |=> res_data_ff[63:32] ==
                         {32{|($past(src2_data[63:32]) | $past(src3_data[63:32]))}})
    else $error("upper quad word of simd or reduction wrong");

  a_word_solid:
    assert property (s_cor_byte_simd |=> res_data_ff[7:0] inside {8'h00, 8'hff})
    else $error("combine-OR byte is neither all ones nor all zeros");

  a_mux_pick:
    assert property (s_mux_issue ##0 (size_sel == CLMU_SIZE_DOUBLE)
                     |=> res_data_ff[15:0] == (($past(src2_data[15:0]) == 16'hffff)
                                               ? $past(src3_data[15:0])
                                               : $past(src1_data[15:0])))
    else $error("word-select picked the wrong source");

  // Issue with an opcode of some other unit
  sequence s_foreign_issue;
    op_valid && !is_cor && !is_mux;
  endsequence

  a_refuse_hold:
    assert property (s_foreign_issue |=> !res_valid_ff && $stable(res_data_ff) &&
                     $stable(res_index_ff))
    else $error("refused opcode changed the result");

  a_scalar_byte:
    assert property (s_cor_issue ##0 !simd_en && (size_sel == CLMU_SIZE_BYTE)
                     |=> res_data_ff[DATA_W-1:`CLMU_BYTE_W] == '0)
    else $error("scalar byte combine-OR left upper bytes set");

  a_mux_quad:
    assert property (s_mux_issue ##0 (size_sel == CLMU_SIZE_QUAD)
                     |=> res_data_ff[63:32] == (($past(src2_data[63:32]) == 32'hffff_ffff)
                                                ? $past(src3_data[63:32])
                                                : $past(src1_data[63:32])))
    else $error("word-select upper quad word from the wrong source");

endmodule : clmu_top

// >>> test/clmu_regfile_model.sv
// Register file model that takes the results of the logic unit
`timescale 1ns/1ps

module clmu_regfile_model (
  input wire logic        clk_sys,
  input wire logic        res_valid_ff,
  input wire logic [5:0]  res_index_ff,
  input wire logic [63:0] res_data_ff
);
  logic [63:0] regs [64];
  int          n_wr = 0;

  // Store each announced result and count the writes
  always @(posedge clk_sys) begin
    if (res_valid_ff === 1'b1) begin
      regs[res_index_ff] <= res_data_ff;
      n_wr <= n_wr + 1;
    end
  end
endmodule : clmu_regfile_model

// >>> test/combine_logic_mux_unit_test.sv
// Self-checking bench for the combine-OR and word-select unit
`timescale 1ns/1ps
`include "clmu_params.svh"

module combine_logic_mux_unit_test;
  logic        clk_sys, reset_n, op_valid, res_valid_ff;
  logic [31:0] instr;
  logic [63:0] src1_data, src2_data, src3_data, res_data_ff, last;
  logic [5:0]  res_index_ff;
  int          n_fail = 0;
  int          n_tests = 0;

  clmu_top u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .op_valid(op_valid), .instr(instr),
    .src1_data(src1_data), .src2_data(src2_data), .src3_data(src3_data),
    .res_valid_ff(res_valid_ff), .res_index_ff(res_index_ff), .res_data_ff(res_data_ff));
  clmu_regfile_model u_rf (.clk_sys(clk_sys), .res_valid_ff(res_valid_ff),
    .res_index_ff(res_index_ff), .res_data_ff(res_data_ff));

  // Clock generation
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task wrap_up;
    if (n_fail == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up

  // Reference result worked out from the instruction fields
  function automatic logic [63:0] ref_res(logic [31:0] i, logic [63:0] a, b, c);
    logic [63:0] f, m, r;
    int w;
    w = 8 << i[23:22];
    m = (64'h1 << w) - 64'h1;
    r = 64'h0;
    case (i[20:18])
      3'h0: f = b & c;
      3'h1: f = b & ~c;
      3'h2: f = b ^ c;
      3'h3: f = b | c;
      3'h4: f = ~(b | c);
      3'h5: f = ~(b ^ c);
      3'h6: f = b | ~c;
      default: f = ~(b & c);
    endcase
    for (int k = 0; k < 64; k++) begin
      if (i[31:24] == `CLMU_OPC_MUX)
        r[k] = (((b >> (k / w * w)) & m) == m) ? c[k] : a[k];
      else if (i[21] || k < w)
        r[k] = |((f >> (k / w * w)) & m);
    end
    return r;
  endfunction : ref_res

  task drive(input logic [31:0] i, input logic [63:0] a, b, c);
    op_valid <= 1'b1;
    instr <= i;
    src1_data <= a;
    src2_data <= b;
    src3_data <= c;
  endtask : drive

  task check_out(input logic [31:0] i, input logic [63:0] a, b, c);
    last = ref_res(i, a, b, c);
    chk("valid", res_valid_ff, 64'h1);
    chk("data", res_data_ff, last);
    chk("index", res_index_ff,
        (i[31:24] == `CLMU_OPC_MUX) ? i[5:0] ^ 6'h01 : i[5:0]);
  endtask : check_out

  task run(input logic [31:0] i, input logic [63:0] a, b, c);
    @(posedge clk_sys);
    drive(i, a, b, c);
    @(posedge clk_sys);
    op_valid <= 1'b0;
    #1 check_out(i, a, b, c);
  endtask : run

  // Every function, size and SIMD setting of combine-OR
  task t_combine;
    for (int s = 0; s < 4; s++)
      for (int f = 0; f < 8; f++)
        for (int m = 0; m < 2; m++)
          run({`CLMU_OPC_COR, s[1:0], m[0], f[2:0], 12'h0, 6'h11}, 64'h0,
              64'h00ff_0000_f000_0180, 64'h0f0f_0000_ff00_0101);
  endtask : t_combine

  // Word-select on every size with partial control words
  task t_select;
    for (int s = 0; s < 4; s++)
      run({`CLMU_OPC_MUX, s[1:0], 4'h0, 12'h0, 6'h2a}, 64'h1111_2222_3333_4444,
          64'hffff_ffff_ff7f_ff00, 64'haaaa_bbbb_cccc_dddd);
  endtask : t_select

  // Two operations on consecutive edges, then the pulse ends
  task t_back2back;
    @(posedge clk_sys);
    drive({`CLMU_OPC_COR, 2'h1, 1'b1, 3'h2, 12'h0, 6'h05}, 64'h0, 64'h00ff, 64'h00ff);
    @(posedge clk_sys);
    drive({`CLMU_OPC_MUX, 2'h0, 4'h0, 12'h0, 6'h07}, 64'h5, 64'hff, 64'ha);
    #1 check_out({`CLMU_OPC_COR, 2'h1, 1'b1, 3'h2, 12'h0, 6'h05}, 64'h0, 64'h00ff,
                 64'h00ff);
    @(posedge clk_sys);
    op_valid <= 1'b0;
    #1 check_out({`CLMU_OPC_MUX, 2'h0, 4'h0, 12'h0, 6'h07}, 64'h5, 64'hff, 64'ha);
    @(posedge clk_sys);
    #1 chk("pulse end", res_valid_ff, 64'h0);
  endtask : t_back2back

  // A foreign opcode leaves the result untouched
  task t_refuse;
    int wr;
    run({`CLMU_OPC_COR, 2'h3, 4'h7, 12'h0, 6'h01}, 64'h0, 64'h1, 64'h0);
    wr = u_rf.n_wr;
    @(posedge clk_sys);
    drive({8'h00, 2'h0, 4'h0, 12'h0, 6'h03}, 64'h0, 64'hff, 64'hff);
    @(posedge clk_sys);
    op_valid <= 1'b0;
    #1 chk("refused valid", res_valid_ff, 64'h0);
    chk("refused data", res_data_ff, last);
    @(posedge clk_sys);
    #1 chk("writes", u_rf.n_wr, wr + 1);
    chk("stored", u_rf.regs[1], last);
  endtask : t_refuse

  // Reset in mid-run clears the outputs and issue resumes after it
  task t_reset;
    run({`CLMU_OPC_MUX, 2'h3, 4'h0, 12'h0, 6'h10}, 64'h0123_4567_89ab_cdef, 64'h0,
        64'h0f0f);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    #1 chk("mid reset valid", res_valid_ff, 64'h0);
    chk("mid reset data", res_data_ff, 64'h0);
    chk("mid reset index", res_index_ff, 64'h0);
    @(posedge clk_sys);
    reset_n <= 1'b1;
    run({`CLMU_OPC_MUX, 2'h3, 4'h0, 12'h0, 6'h10}, 64'h0123_4567_89ab_cdef, '1,
        64'h0f0f);
  endtask : t_reset

  // Main sequence
  initial begin
    reset_n = 1'b0;
    op_valid = 1'b0;
    instr = 32'h0;
    {src1_data, src2_data, src3_data} = '0;
    repeat (8) @(posedge clk_sys);
    chk("reset data", res_data_ff, 64'h0);
    chk("reset valid", res_valid_ff, 64'h0);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    t_combine;
    t_select;
    t_back2back;
    t_refuse;
    t_reset;
    wrap_up;
  end

  // Watchdog
  initial begin
    #(50 * 2000);
    n_fail++;
    wrap_up;
  end
endmodule : combine_logic_mux_unit_test
